// ===== core/jmr_exec.v
// Contract
// - Jump loads PC with instruction address, fetches there, flags unchanged.
// - Jump takes two cycles with a dummy cycle during PC load.
// - Load-from-RAM copies addressed byte to working register, flags unchanged.
// - Load-immediate puts literal into working register, flags unchanged.
// - Store writes working register to RAM, register and flags unchanged.
// - Idle instruction changes nothing and advances to next instruction.
// - OR-with-RAM result goes to working register, only zero flag updates.
// - OR-immediate result goes to working register, only zero flag updates.
// - Merge-into-RAM result written back to RAM, only zero flag updates.
// - Subroutine exit pops stack into PC, flags unchanged.
// - Exit-with-literal pops PC, loads literal into working register.
`timescale 1ns/1ps
`default_nettype none
`include "jmr_map.vh"

// Execute stage for the jump, transfer, idle, merge and exit group.
// Fetch hands over one decoded instruction per cycle, qualified by
// instr_valid. Every register update lands on the rising edge at which
// the instruction is taken (the RAM write one edge later), so the next instruction already sees
// the new working register and zero flag with no forwarding path.
// Ops that reload the program counter leave one dead slot behind them:
// the word that fetch presents in that slot was fetched from the old
// address, so it is dropped here rather than undone later.
// Op codes outside the decoded set behave as the idle instruction; this
// keeps a corrupt fetch from freezing the counter.

module jmr_exec #(
    parameter DW = 8,
    parameter AW = 8,
    parameter PCW = 13
) (
    // Clock and reset.
    input wire sys_clk,
    input wire resetn,
    // Decoded instruction from fetch.
    input wire instr_valid,
    input wire [`JMR_OP_W-1:0] instr_op,
    input wire [DW-1:0] instr_lit,
    input wire [AW-1:0] instr_addr,
    input wire [PCW-1:0] instr_target,
    // Data RAM port; read data is combinational for ram_addr.
    output wire [AW-1:0] ram_addr,
    input wire [DW-1:0] ram_rdata,
    output reg ram_we,
    output reg [AW-1:0] ram_waddr,
    output reg [DW-1:0] ram_wdata,
    // Return stack.
    input wire [PCW-1:0] stack_top,
    output wire stack_pop,
    // Program counter and pipeline control.
    output reg [PCW-1:0] pc,
    output wire flush,
    // Architectural state.
    output reg [DW-1:0] working_register,
    output reg zero_flag
);

    localparam ST_RUN = 1'b0;
    localparam ST_DUMMY = 1'b1;

    reg state_r;
    reg state_nxt;
    reg [PCW-1:0] pc_nxt;
    reg [DW-1:0] wreg_nxt;
    reg zf_nxt;
    reg we_nxt;
    reg [DW-1:0] wdata_nxt;
    wire [DW-1:0] or_b;
    wire [DW-1:0] or_y;
    wire or_zero;
    wire go;

    // An instruction is taken only in the run state; the dummy slot
    // discards whatever fetch presents, which is the prefetched word.
    assign go = instr_valid && (state_r == ST_RUN);
    assign ram_addr = instr_addr;

    // Immediate form selects the literal, other forms the RAM byte.
    assign or_b = (instr_op == `JMR_OP_OR_IMM) ? instr_lit : ram_rdata;

    jmr_or_unit #(
        .DW(DW)
    ) u_or (
        .a(working_register),
        .b(or_b),
        .y(or_y),
        .zero(or_zero)
    );

    // Ops that pop the return stack. The pop strobe and the redirect
    // decode share this, so both always agree on which ops leave.
    function is_exit;
        input [`JMR_OP_W-1:0] op;
        begin
            is_exit = (op == `JMR_OP_EXIT) || (op == `JMR_OP_EXIT_LIT);
        end
    endfunction

    // Ops that reload the counter from outside the sequence, and so cost
    // a dead slot while fetch refills from the new address.
    function is_redirect;
        input [`JMR_OP_W-1:0] op;
        begin
            is_redirect = (op == `JMR_OP_JUMP) || is_exit(op);
        end
    endfunction

    // Pop and flush are pulses in the cycle the redirecting op is taken.
    // They are combinational so the stack and fetch act in the same cycle.
    assign stack_pop = go && is_exit(instr_op);
    assign flush = go && is_redirect(instr_op);

    // Next-state decode of one instruction.
    always @* begin
        state_nxt = ST_RUN;
        pc_nxt = pc;
        wreg_nxt = working_register;
        zf_nxt = zero_flag;
        we_nxt = 1'b0;
        // Holding the write data avoids a needless toggle on the RAM bus.
        wdata_nxt = ram_wdata;
        if (go) begin
            pc_nxt = pc + {{(PCW-1){1'b0}}, 1'b1};
            case (instr_op)
                `JMR_OP_JUMP: begin
                    pc_nxt = instr_target;
                    // insert dummy cycle.
                    // The flag register is left alone on purpose.
                    state_nxt = ST_DUMMY;
                end
                `JMR_OP_LOAD_RAM: begin
                    // The RAM read is combinational, so the byte is ready
                    // in the same cycle as the address.
                    // copy RAM byte.
                    wreg_nxt = ram_rdata;
                end
                `JMR_OP_LOAD_IMM: begin
                    wreg_nxt = instr_lit;
                end
                `JMR_OP_STORE: begin
                    we_nxt = 1'b1;
                    wdata_nxt = working_register;
                end
                `JMR_OP_OR_RAM, `JMR_OP_OR_IMM: begin
                    wreg_nxt = or_y;
                    zf_nxt = or_zero;
                end
                `JMR_OP_MERGE_RAM: begin
                    we_nxt = 1'b1;
                    wdata_nxt = or_y;
                    zf_nxt = or_zero;
                end
                `JMR_OP_EXIT: begin
                    pc_nxt = stack_top;
                    state_nxt = ST_DUMMY;
                end
                `JMR_OP_EXIT_LIT: begin
                    pc_nxt = stack_top;
                    wreg_nxt = instr_lit;
                    // The literal lands with the new counter value, so the
                    // caller sees it at the first word after the exit.
                    state_nxt = ST_DUMMY;
                end
                default: begin
                    pc_nxt = pc + {{(PCW-1){1'b0}}, 1'b1};
                end
            endcase
        end
    end

    // State registers; the RAM write strobe lasts one cycle.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            state_r <= ST_RUN;
            pc <= `JMR_RST_PC;
            working_register <= `JMR_RST_WREG;
            zero_flag <= 1'b0;
            ram_we <= 1'b0;
            ram_waddr <= {AW{1'b0}};
            ram_wdata <= {DW{1'b0}};
        end else begin
            state_r <= state_nxt;
            pc <= pc_nxt;
            working_register <= wreg_nxt;
            zero_flag <= zf_nxt;
            ram_we <= we_nxt;
            ram_wdata <= wdata_nxt;
            if (we_nxt) begin
                ram_waddr <= instr_addr;
            end
        end
    end

endmodule

`default_nettype wire

// ===== core/jmr_map.vh
`ifndef JMR_MAP_VH
`define JMR_MAP_VH

// Operation codes seen by the execute stage (already decoded from fetch).
`define JMR_OP_W 4
`define JMR_OP_IDLE 4'h0
`define JMR_OP_JUMP 4'h1
`define JMR_OP_LOAD_RAM 4'h2
`define JMR_OP_LOAD_IMM 4'h3
`define JMR_OP_STORE 4'h4
`define JMR_OP_OR_RAM 4'h5
`define JMR_OP_OR_IMM 4'h6
`define JMR_OP_MERGE_RAM 4'h7
`define JMR_OP_EXIT 4'h8
`define JMR_OP_EXIT_LIT 4'h9

// Reset values.
`define JMR_RST_PC 13'h0000
`define JMR_RST_WREG 8'h00

`endif

// ===== core/jmr_or_unit.v
`timescale 1ns/1ps
`default_nettype none

// Bitwise OR with zero detect; shared by all three merge forms.
module jmr_or_unit #(
    parameter DW = 8
) (
    // Operands.
    input wire [DW-1:0] a,
    input wire [DW-1:0] b,
    // Result.
    output wire [DW-1:0] y,
    output wire zero
);

    // Zero flag follows the full result width.
    assign y = a | b;
    assign zero = (y == {DW{1'b0}});

endmodule

`default_nettype wire

// ===== sim/jmr_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "jmr_map.vh"
module jmr_monitor (
    // Clock and reset.
    input wire sys_clk,
    input wire resetn,
    // Instruction and far side.
    input wire instr_valid,
    input wire [3:0] instr_op,
    input wire [7:0] instr_lit,
    input wire [7:0] instr_addr,
    input wire [12:0] instr_target,
    input wire [7:0] ram_rdata,
    input wire [12:0] stack_top,
    // Outputs.
    input wire ram_we,
    input wire [7:0] ram_waddr,
    input wire [7:0] ram_wdata,
    input wire stack_pop,
    input wire [12:0] pc,
    input wire [7:0] working_register,
    input wire zero_flag
);
    reg dead_r;
    // One strobe per taken op; the slot after a redirect is masked.
    wire [15:0] k = {15'h0, instr_valid & ~dead_r} << instr_op;
    wire ex = k[`JMR_OP_EXIT] | k[`JMR_OP_EXIT_LIT];
    wire [7:0] w = working_register;
    // Own dead-slot tracking, so a wrong flush cannot hide a fault.
    always @(posedge sys_clk)
        dead_r <= resetn & (ex | k[`JMR_OP_JUMP]);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_jump_target: assert property (k[`JMR_OP_JUMP] |=>
        pc == $past(instr_target) && $stable(zero_flag)) else $error("jump");
    chk_dead_slot: assert property (dead_r |=>
        $stable(pc) && $stable(w) && !ram_we) else $error("dead slot acted");
    chk_lit_load: assert property (k[`JMR_OP_LOAD_IMM] | k[`JMR_OP_EXIT_LIT]
        |=> w == $past(instr_lit)) else $error("literal load");
    chk_store_data: assert property (k[`JMR_OP_STORE] |=>
        ram_we && ram_wdata == $past(w) && $stable(w)) else $error("store");
    chk_idle_step: assert property (k[`JMR_OP_IDLE] |=>
        pc == $past(pc) + 13'h1 && $stable(w)) else $error("idle");
    chk_or_ram: assert property (k[`JMR_OP_OR_RAM] |=>
        w == $past(w | ram_rdata) && zero_flag == ~|w) else $error("or ram");
    chk_merge_ram: assert property (k[`JMR_OP_MERGE_RAM] |=>
        ram_we && ram_wdata == $past(w | ram_rdata) && zero_flag == ~|ram_wdata)
        else $error("merge");
    chk_exit_pop: assert property (ex |-> stack_pop ##1
        pc == $past(stack_top) && $stable(zero_flag)) else $error("exit");
endmodule
`default_nettype wire

// ===== sim/jmr_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "jmr_map.vh"
module jmr_exec_tb;
    reg sys_clk = 0, resetn = 0, instr_valid = 0, ez = 0, ex, st;
    reg [3:0] instr_op = 0;
    reg [7:0] instr_lit = 0, instr_addr = 0, ew = 0, r, mem [0:255];
    reg [12:0] instr_target = 0, stack_top = 0, ep = 0;
    integer seed = 32'h3dca0880, num_errors = 0, n_compared = 0, i;
    wire [7:0] ram_addr, ram_waddr, ram_wdata, working_register;
    wire [12:0] pc;
    wire ram_we, stack_pop, flush, zero_flag;
    wire [7:0] ram_rdata = mem[ram_addr];
    jmr_exec dut_u (.*);
    // Clock, and a RAM whose writes land on the rising edge.
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ram_we) mem[ram_waddr] <= ram_wdata;
    // Result byte of an op; ops without one keep the working register.
    function [7:0] res(input [3:0] op, input [7:0] w, d, x);
        case (op)
            `JMR_OP_LOAD_RAM: res = d;
            `JMR_OP_LOAD_IMM, `JMR_OP_EXIT_LIT: res = x;
            `JMR_OP_OR_RAM, `JMR_OP_MERGE_RAM: res = w | d;
            `JMR_OP_OR_IMM: res = w | x;
            default: res = w;
        endcase
    endfunction
    task chk(input [12:0] got, exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Presents one op at a falling edge and checks it one cycle later.
    task run(input [3:0] op, input [7:0] lit);
        begin
            instr_valid = 1'b1;
            instr_op = op;
            instr_lit = lit;
            {instr_target, stack_top, instr_addr[3:0]} = $random(seed);
            r = res(op, ew, mem[instr_addr], lit);
            st = op == `JMR_OP_STORE || op == `JMR_OP_MERGE_RAM;
            ex = op == `JMR_OP_EXIT || op == `JMR_OP_EXIT_LIT;
            #1;
            chk(flush, ex || op == `JMR_OP_JUMP);
            chk(stack_pop, ex);
            ep = ex ? stack_top : op == `JMR_OP_JUMP ? instr_target : ep + 13'h1;
            if (op >= `JMR_OP_OR_RAM && op <= `JMR_OP_MERGE_RAM)
                ez = r == 8'h00;
            if (op != `JMR_OP_MERGE_RAM)
                ew = r;
            @(negedge sys_clk);
            chk(pc, ep);
            chk(working_register, ew);
            chk(zero_flag, ez);
            chk(ram_we, st);
            if (st) begin
                chk(ram_wdata, r);
                chk(ram_waddr, instr_addr);
            end
            // A store in the dead slot must not move the counter; chk keeps only the low 13 bits, so {ram_we, pc} compares pc alone.
            if (ex || op == `JMR_OP_JUMP) begin
                instr_op = `JMR_OP_STORE;
                @(negedge sys_clk);
                chk({ram_we, pc}, ep);
            end
        end
    endtask
    task conclude;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = $random(seed);
        repeat (8) @(negedge sys_clk);
        chk({ram_we, zero_flag, working_register}, 13'h0);
        resetn = 1'b1;
        for (i = 0; i < 16; i = i + 1)
            run(i[3:0], 8'h5a);
        run(`JMR_OP_LOAD_IMM, 8'h00);
        run(`JMR_OP_OR_IMM, 8'h00);
        $display("corner tests done");
        for (i = 0; i < 600; i = i + 1) begin
            r = $random(seed);
            run(r[7:4], r);
        end
        $display("random tests done");
        conclude;
    end
endmodule
bind jmr_exec jmr_monitor mon_u (.*);
`default_nettype wire
